// File: hw/cfr_frame_ctrl.sv
/*
 Timing generator that drives an interline area sensor: frame transfer,
 line transfers, horizontal readout, line summing, line dump, shutter.
 Assumes pins go to level shifting drivers and that the analog front end
 samples video on O_SAMPLE before the sense node clear pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module cfr_frame_ctrl #(
    parameter int unsigned ROWS = cfr_pkg::ROWS,
    parameter int unsigned STAGES = cfr_pkg::STAGES
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    // Command
    input wire logic I_START,
    input wire cfr_pkg::cfr_mode_t I_MODE,
    input wire logic I_SHUTTER_EN,
    input wire logic [10:0] I_SHUTTER_LINE,
    // Sensor pins
    output cfr_pkg::cfr_pins_t O_PINS,
    // Front end
    output logic O_SAMPLE,
    output logic O_LINE_VALID,
    output logic O_BUSY,
    output logic O_FRAME_DONE
);
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_FRAME_XFER,
        ST_V2_HIGH,
        ST_V2_LOW,
        ST_MOVE_LOWER,
        ST_UPPER_BACK,
        ST_READ_H1,
        ST_READ_H2,
        ST_READ_RST,
        ST_RETRACE
    } cfr_state_t;

    typedef struct packed {
        cfr_state_t st;
        cfr_pkg::cfr_mode_t mode;
        logic shut_en;
        logic [10:0] shut_line;
        logic [10:0] line;
        logic [10:0] stage;
        logic [7:0] tmr;
        logic second;
        cfr_pkg::cfr_pins_t pins;
        logic sample;
        logic line_valid;
        logic busy;
        logic done;
    } cfr_ctrl_t;

    cfr_ctrl_t s_q;
    cfr_ctrl_t s_d;
    logic pix_tick;
    logic pix_run;

    // ==========================================================
    // Pixel rate
    assign pix_run = (s_q.st == ST_READ_H1) || (s_q.st == ST_READ_H2)
        || (s_q.st == ST_READ_RST);

    cfr_pixel_div u_div (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_run(pix_run),
        .o_tick(pix_tick)
    );

    function automatic logic last_line(input logic [10:0] l);
        last_line = (l >= 11'(ROWS - 1));
    endfunction : last_line

    function automatic logic [7:0] cyc8(input int unsigned c);
        cyc8 = 8'(c);
    endfunction : cyc8

    // ==========================================================
    // Sequencer
    always_comb
    begin
        s_d = s_q;
        s_d.sample = 1'b0;
        s_d.done = 1'b0;
        if (s_q.tmr != 8'h00)
        begin
            s_d.tmr = s_q.tmr - 8'h01;
        end
        case (s_q.st)
            ST_IDLE:
            begin
                s_d.pins = cfr_pkg::PINS_RESET;
                s_d.busy = 1'b0;
                if (I_START)
                begin
                    s_d.mode = I_MODE;
                    s_d.shut_en = I_SHUTTER_EN;
                    s_d.shut_line = I_SHUTTER_LINE;
                    s_d.line = 11'h000;
                    s_d.second = 1'b0;
                    s_d.busy = 1'b1;
                    s_d.pins.vertical_phase_one_xfer = 1'b1;
                    s_d.tmr = cyc8(cfr_pkg::XFER_CYC);
                    s_d.st = ST_FRAME_XFER;
                end
            end
            ST_FRAME_XFER:
            begin
                if (s_q.tmr == 8'h00)
                begin
                    // Transfer fall closes the exposure
                    s_d.pins.vertical_phase_one_xfer = 1'b0;
                    s_d.tmr = cyc8(cfr_pkg::PHASE_CYC);
                    s_d.st = ST_V2_HIGH;
                end
            end
            ST_V2_HIGH:
            begin
                if (s_q.tmr == 8'h00)
                begin
                    // Upper held high while phase two pulses
                    s_d.pins.horizontal_phase_one_upper = 1'b1;
                    s_d.pins.horizontal_phase_two = 1'b0;
                    s_d.pins.vertical_phase_one = 1'b0;
                    s_d.pins.vertical_phase_two = 1'b1;
                    s_d.pins.line_discard_gate = (s_q.mode == cfr_pkg::CFR_MODE_DUMP);
                    s_d.tmr = cyc8(cfr_pkg::XFER_CYC);
                    s_d.st = ST_V2_LOW;
                end
            end
            ST_V2_LOW:
            begin
                if (s_q.tmr == 8'h00)
                begin
                    s_d.pins.vertical_phase_two = 1'b0;
                    s_d.pins.vertical_phase_one = 1'b1;
                    s_d.pins.line_discard_gate = 1'b0;
                    s_d.tmr = cyc8(cfr_pkg::PHASE_CYC);
                    s_d.line = s_q.line + 11'h001;
                    if (s_q.mode == cfr_pkg::CFR_MODE_DUMP)
                    begin
                        s_d.tmr = cyc8(cfr_pkg::RETRACE_CYC);
                        s_d.st = ST_RETRACE;
                    end
                    else if (s_q.mode == cfr_pkg::CFR_MODE_SUM2 && !s_q.second
                        && !last_line(s_q.line))
                    begin
                        s_d.second = 1'b1;
                        s_d.st = ST_V2_HIGH;
                    end
                    else if (s_q.mode == cfr_pkg::CFR_MODE_DUAL && !s_q.second
                        && !last_line(s_q.line))
                    begin
                        s_d.st = ST_MOVE_LOWER;
                    end
                    else
                    begin
                        s_d.second = 1'b0;
                        s_d.stage = 11'h000;
                        s_d.line_valid = 1'b1;
                        s_d.st = ST_READ_H1;
                    end
                end
            end
            ST_MOVE_LOWER:
            begin
                if (s_q.tmr == 8'h00)
                begin
                    s_d.pins.horizontal_phase_two = 1'b0;
                    s_d.pins.horizontal_phase_one_upper = 1'b0;
                    s_d.pins.horizontal_phase_one_lower = 1'b1;
                    s_d.tmr = cyc8(cfr_pkg::XFER_CYC);
                    s_d.st = ST_UPPER_BACK;
                end
            end
            ST_UPPER_BACK:
            begin
                if (s_q.tmr == 8'h00)
                begin
                    s_d.pins.horizontal_phase_one_upper = 1'b1;
                    s_d.second = 1'b1;
                    s_d.tmr = cyc8(cfr_pkg::PHASE_CYC);
                    s_d.st = ST_V2_HIGH;
                end
            end
            ST_READ_H1:
            begin
                if (pix_tick)
                begin
                    s_d.pins.horizontal_phase_one_upper = 1'b0;
                    s_d.pins.horizontal_phase_one_lower = 1'b0;
                    s_d.pins.horizontal_phase_two = 1'b1;
                    s_d.st = ST_READ_H2;
                end
            end
            ST_READ_H2:
            begin
                if (pix_tick)
                begin
                    // Falling edge moves packet to sense node
                    s_d.pins.horizontal_phase_two = 1'b0;
                    s_d.pins.horizontal_phase_one_upper = 1'b1;
                    // Lower clocked only in dual mode, else held low
                    s_d.pins.horizontal_phase_one_lower =
                        (s_q.mode == cfr_pkg::CFR_MODE_DUAL);
                    s_d.sample = 1'b1;
                    s_d.st = ST_READ_RST;
                end
            end
            ST_READ_RST:
            begin
                if (pix_tick && !s_q.pins.sense_node_reset)
                begin
                    s_d.pins.sense_node_reset = 1'b1;
                end
                else if (pix_tick)
                begin
                    s_d.pins.sense_node_reset = 1'b0;
                    // Every stage, dark ones included, is clocked out
                    if (s_q.stage == 11'(STAGES - 1))
                    begin
                        s_d.line_valid = 1'b0;
                        s_d.second = 1'b0;
                        s_d.tmr = cyc8(cfr_pkg::RETRACE_CYC);
                        s_d.st = ST_RETRACE;
                    end
                    else
                    begin
                        s_d.stage = s_q.stage + 11'h001;
                        s_d.st = ST_READ_H1;
                    end
                end
            end
            ST_RETRACE:
            begin
                // Shutter issued only here, in the chosen retrace
                // Fixed retrace length keeps frame timing unchanged
                s_d.pins.shutter_pulse_level = s_q.shut_en && (s_q.line == s_q.shut_line)
                    && (s_q.tmr <= cyc8(cfr_pkg::SHUT_CYC + cfr_pkg::PHASE_CYC))
                    && (s_q.tmr > cyc8(cfr_pkg::PHASE_CYC));
                if (s_q.tmr == 8'h00)
                begin
                    if (s_q.line >= 11'(ROWS))
                    begin
                        s_d.done = 1'b1;
                        s_d.st = ST_IDLE;
                    end
                    else
                    begin
                        s_d.st = ST_V2_HIGH;
                    end
                end
            end
            default:
            begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            s_q <= '{st: ST_IDLE, mode: cfr_pkg::CFR_MODE_SINGLE,
                pins: cfr_pkg::PINS_RESET, default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign O_PINS = s_q.pins;
    assign O_SAMPLE = s_q.sample;
    assign O_LINE_VALID = s_q.line_valid;
    assign O_BUSY = s_q.busy;
    assign O_FRAME_DONE = s_q.done;
endmodule : cfr_frame_ctrl
`default_nettype wire

// File: common/cfr_pkg.sv
/*
 Package for the area sensor timing controller: frame geometry,
 sequencer timing constants, mode encodings and pin carrier struct.
 Assumes a single 20 MHz clock shared by every user.
*/
package cfr_pkg;
    // ==========================================================
    // Geometry
    localparam int unsigned COLUMNS = 1024;
    localparam int unsigned ROWS = 1024;
    localparam int unsigned STAGES = 1032;
    localparam int unsigned DARK_COLUMNS = 16;
    localparam int unsigned DARK_ROWS = 6;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ = 20;
    localparam int unsigned XFER_NS = 1000;
    localparam int unsigned XFER_CYC = (XFER_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PHASE_NS = 100;
    localparam int unsigned PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SHUT_NS = 500;
    localparam int unsigned SHUT_CYC = (SHUT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PIX_DIV = 2;
    localparam int unsigned RETRACE_CYC = SHUT_CYC + 2 * PHASE_CYC;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        CFR_MODE_SINGLE,
        CFR_MODE_DUAL,
        CFR_MODE_SUM2,
        CFR_MODE_DUMP
    } cfr_mode_t;

    typedef struct packed {
        logic vertical_phase_one_xfer;
        logic vertical_phase_one;
        logic vertical_phase_two;
        logic horizontal_phase_one_upper;
        logic horizontal_phase_one_lower;
        logic horizontal_phase_two;
        logic sense_node_reset;
        logic line_discard_gate;
        logic shutter_pulse_level;
    } cfr_pins_t;

    localparam cfr_pins_t PINS_RESET = '{
        vertical_phase_one_xfer: 1'b0,
        vertical_phase_one: 1'b1,
        vertical_phase_two: 1'b0,
        horizontal_phase_one_upper: 1'b1,
        horizontal_phase_one_lower: 1'b1,
        horizontal_phase_two: 1'b0,
        sense_node_reset: 1'b0,
        line_discard_gate: 1'b0,
        shutter_pulse_level: 1'b0
    };
endpackage : cfr_pkg

// File: hw/cfr_pixel_div.sv
/*
 Pixel rate divider: one-cycle enable pulse every DIV clocks while run.
 Assumes synchronous inputs on the single system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cfr_pixel_div #(
    parameter int unsigned DIV = cfr_pkg::PIX_DIV
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_run,
    output logic o_tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } cfr_div_t;

    cfr_div_t s_q;
    cfr_div_t s_d;

    // ==========================================================
    // Next state
    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!i_run)
        begin
            s_d.cnt = 8'h00;
        end
        else if (s_q.cnt == 8'(DIV - 1))
        begin
            s_d.cnt = 8'h00;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;
endmodule : cfr_pixel_div
`default_nettype wire

// File: verification/cfr_frame_properties.sv
/*
 Checker for the sensor timing controller, bound to its top module.
 Assumes one clock domain and the registered outputs of the controller.
*/
`timescale 1ns/10ps
`default_nettype none
module cfr_frame_chk #(
    parameter int unsigned ROWS = cfr_pkg::ROWS,
    parameter int unsigned STAGES = cfr_pkg::STAGES
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    // Command
    input wire logic I_START,
    input wire cfr_pkg::cfr_mode_t I_MODE,
    input wire logic I_SHUTTER_EN,
    input wire logic [10:0] I_SHUTTER_LINE,
    // Outputs
    input wire cfr_pkg::cfr_pins_t O_PINS,
    input wire logic O_SAMPLE,
    input wire logic O_LINE_VALID,
    input wire logic O_BUSY,
    input wire logic O_FRAME_DONE
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);
    property p_v_excl;
        !(O_PINS.vertical_phase_one && O_PINS.vertical_phase_two);
    endproperty
    a_v_excl: assert property (p_v_excl) else $error("Vertical overlap");
    property p_h_excl;
        !(O_PINS.horizontal_phase_one_upper && O_PINS.horizontal_phase_two);
    endproperty
    a_h_excl: assert property (p_h_excl) else $error("Horizontal overlap");
    property p_hl_excl;
        !(O_PINS.horizontal_phase_one_lower && O_PINS.horizontal_phase_two);
    endproperty
    a_hl_excl: assert property (p_hl_excl) else $error("Lower overlap");
    property p_start;
        I_START && !O_BUSY |=> (O_BUSY && O_PINS.vertical_phase_one_xfer) [*8];
    endproperty
    a_start: assert property (p_start) else $error("Frame transfer late");
    property p_sample;
        O_SAMPLE |-> $fell(O_PINS.horizontal_phase_two);
    endproperty
    a_sample: assert property (p_sample) else $error("Sample off phase");
    property p_clear;
        O_SAMPLE |-> ##[1:3] O_PINS.sense_node_reset;
    endproperty
    a_clear: assert property (p_clear) else $error("No node clear");
    property p_shut;
        O_PINS.shutter_pulse_level |-> !O_LINE_VALID && !O_SAMPLE;
    endproperty
    a_shut: assert property (p_shut) else $error("Shutter in readout");
    property p_dump;
        O_PINS.line_discard_gate |-> !O_LINE_VALID && !O_SAMPLE;
    endproperty
    a_dump: assert property (p_dump) else $error("Dump during readout");
    property p_move;
        O_PINS.horizontal_phase_one_lower && !O_PINS.horizontal_phase_one_upper
            |-> !O_PINS.horizontal_phase_two;
    endproperty
    a_move: assert property (p_move) else $error("Lower move bad");
    property p_done;
        O_FRAME_DONE |-> O_BUSY ##1 !O_FRAME_DONE;
    endproperty
    a_done: assert property (p_done) else $error("Done not a pulse");
endmodule : cfr_frame_chk
bind cfr_frame_ctrl cfr_frame_chk #(.ROWS(ROWS), .STAGES(STAGES)) chk_u (
    .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_START(I_START), .I_MODE(I_MODE),
    .I_SHUTTER_EN(I_SHUTTER_EN), .I_SHUTTER_LINE(I_SHUTTER_LINE),
    .O_PINS(O_PINS), .O_SAMPLE(O_SAMPLE), .O_LINE_VALID(O_LINE_VALID),
    .O_BUSY(O_BUSY), .O_FRAME_DONE(O_FRAME_DONE));
`default_nettype wire

// File: verification/cfr_sensor_model.sv
/*
 Behavioural sensor model: counts charge moves seen on the clock pins.
 Assumes the bench clears its counters before each scenario and reads them after its frames.
*/
`timescale 1ns/10ps
`default_nettype none
module cfr_sensor_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Sensor pins
    input wire cfr_pkg::cfr_pins_t i_pins
);
    cfr_pkg::cfr_pins_t p_q = cfr_pkg::PINS_RESET;
    int frames = 0, lines = 0, dumped = 0, shifts = 0, lower = 0;
    int shutters = 0, expo = 0, expo_cnt = 0;
    bit run = 0;
    always @(posedge i_clk)
    begin
        p_q <= i_pins;
        expo_cnt <= expo_cnt + 1;
        if (p_q.vertical_phase_one_xfer && !i_pins.vertical_phase_one_xfer)
        begin
            frames <= frames + 1;
            if (run)
                expo <= expo_cnt;
            run <= 1'b0;
        end
        if (p_q.vertical_phase_two && !i_pins.vertical_phase_two)
        begin
            lines <= lines + 1;
            if (i_pins.line_discard_gate || p_q.line_discard_gate)
                dumped <= dumped + 1;
        end
        if (p_q.horizontal_phase_two && !i_pins.horizontal_phase_two)
            shifts <= shifts + 1;
        if (p_q.horizontal_phase_one_upper && !i_pins.horizontal_phase_one_upper
            && i_pins.horizontal_phase_one_lower && !i_pins.horizontal_phase_two)
            lower <= lower + 1;
        if (p_q.shutter_pulse_level && !i_pins.shutter_pulse_level)
        begin
            shutters <= shutters + 1;
            run <= 1'b1;
            expo_cnt <= 0;
        end
    end
endmodule : cfr_sensor_model
`default_nettype wire

// File: verification/cfr_frame_ctrl_tb_top.sv
/*
 Self-checking bench for the sensor timing controller with a sensor model.
 Assumes shrunk geometry of 4 rows and 8 stages.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
    begin \
        check_count++; \
        if ((a) !== (b)) \
        begin \
            $display("Error at %0t: got %h expected %h", $time, (a), (b)); \
            failures++; \
        end \
    end
module cfr_frame_ctrl_tb_top;
    localparam int RW = 4;
    localparam int ST = 8;
    logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, sh_en = 1'b0;
    cfr_pkg::cfr_mode_t mode = cfr_pkg::CFR_MODE_SINGLE;
    logic [10:0] sh_line = 11'h000;
    cfr_pkg::cfr_pins_t pins;
    logic sample, lvalid, busy, done;
    int failures = 0, check_count = 0, ticks = 0;
    int n_samp = 0;
    cfr_frame_ctrl #(.ROWS(RW), .STAGES(ST)) dut_u (
        .I_MCLK(clk), .I_RST_N(rst_n), .I_START(start), .I_MODE(mode),
        .I_SHUTTER_EN(sh_en), .I_SHUTTER_LINE(sh_line), .O_PINS(pins),
        .O_SAMPLE(sample), .O_LINE_VALID(lvalid), .O_BUSY(busy), .O_FRAME_DONE(done));
    cfr_sensor_model model_u (.i_clk(clk), .i_rst_n(rst_n), .i_pins(pins));
    initial
    begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        ticks++;
        if (sample === 1'b1)
            n_samp++;
        if (ticks == 40000)
        begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // Frame driver
    task automatic clear_model();
        @(negedge clk);
        model_u.lines = 0;
        model_u.dumped = 0;
        model_u.shifts = 0;
        model_u.lower = 0;
        model_u.shutters = 0;
        model_u.frames = 0;
    endtask : clear_model
    task automatic run_frame(input cfr_pkg::cfr_mode_t m, input logic en,
        input logic [10:0] ln, output int cyc);
        @(posedge clk);
        start <= 1'b1;
        mode <= m;
        sh_en <= en;
        sh_line <= ln;
        @(posedge clk);
        start <= 1'b0;
        cyc = 0;
        @(negedge clk);
        while (done !== 1'b1 && cyc < 5000)
        begin
            @(negedge clk);
            cyc++;
        end
        `CHK(done, 1'b1)
        repeat (2) @(negedge clk);
        `CHK(busy, 1'b0)
    endtask : run_frame
    // ==========================================================
    // Scenarios
    task automatic t_modes();
        int c;
        for (int i = 0; i < 4; i++)
        begin
            clear_model();
            n_samp = 0;
            run_frame(cfr_pkg::cfr_mode_t'(i), 1'b0, 11'h000, c);
            `CHK(n_samp, i == 0 ? RW * ST : (i == 3 ? 0 : RW * ST / 2))
            `CHK(model_u.frames, 1)
            `CHK(model_u.lines, RW)
            `CHK(model_u.shifts, i == 0 ? RW * ST : (i == 3 ? 0 : RW * ST / 2))
            `CHK(model_u.lower, i == 1 ? RW / 2 : 0)
            `CHK(model_u.dumped, i == 3 ? RW : 0)
        end
    endtask : t_modes
    task automatic t_refuse();
        int c;
        clear_model();
        fork
            run_frame(cfr_pkg::CFR_MODE_SINGLE, 1'b0, 11'h000, c);
            begin
                repeat (60) @(posedge clk);
                start <= 1'b1;
                mode <= cfr_pkg::CFR_MODE_DUMP;
                @(posedge clk);
                start <= 1'b0;
            end
        join
        `CHK(model_u.frames, 1)
        `CHK(model_u.dumped, 0)
    endtask : t_refuse
    task automatic t_back_to_back();
        int c;
        clear_model();
        run_frame(cfr_pkg::CFR_MODE_SINGLE, 1'b0, 11'h000, c);
        @(posedge clk);
        start <= 1'b1;
        repeat (2 * c) @(posedge clk);
        start <= 1'b0;
        repeat (3 * c) @(posedge clk);
        `CHK(model_u.frames > 2, 1'b1)
        `CHK(busy, 1'b0)
    endtask : t_back_to_back
    task automatic t_shutter();
        int c0, c1, c2, e1;
        clear_model();
        run_frame(cfr_pkg::CFR_MODE_SINGLE, 1'b1, 11'h001, c1);
        `CHK(model_u.shutters, 1)
        run_frame(cfr_pkg::CFR_MODE_SINGLE, 1'b0, 11'h000, c0);
        e1 = model_u.expo;
        run_frame(cfr_pkg::CFR_MODE_SINGLE, 1'b1, 11'h002, c2);
        run_frame(cfr_pkg::CFR_MODE_SINGLE, 1'b0, 11'h000, c0);
        `CHK(c1, c0)
        `CHK(c2, c0)
        `CHK(e1 > model_u.expo, 1'b1)
        `CHK(model_u.shutters, 2)
    endtask : t_shutter
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK(pins, cfr_pkg::PINS_RESET)
        t_modes();
        t_refuse();
        t_back_to_back();
        t_shutter();
        print_verdict();
    end
endmodule : cfr_frame_ctrl_tb_top
`default_nettype wire
